// [rtcrc_pkg.sv]
package rtcrc_pkg;

    // Event and flag bit positions.
    localparam int EV_32HZ = 0;
    localparam int EV_8HZ = 1;
    localparam int EV_4HZ = 2;
    localparam int EV_1HZ = 3;
    localparam int EV_TENSEC = 4;
    localparam int EV_MINUTE = 5;
    localparam int EV_TENMIN = 6;
    localparam int EV_HOUR = 7;
    localparam int EV_HALFDAY = 8;
    localparam int EV_DAY = 9;
    localparam int EV_COUNT = 10;

    // Tick rate and prescaler taps.
    localparam int TICK_HZ = 256;
    localparam int PRESC_W = 8;
    localparam logic [PRESC_W-1:0] PRESC_32HZ_MASK = 8'h07;
    localparam logic [PRESC_W-1:0] PRESC_8HZ_MASK = 8'h1F;
    localparam logic [PRESC_W-1:0] PRESC_4HZ_MASK = 8'h3F;
    localparam logic [PRESC_W-1:0] PRESC_1HZ_MASK = 8'hFF;
    localparam logic [PRESC_W-1:0] PRESC_RESET = 8'h00;

    // Counter limits in binary and decimal-digit form.
    localparam logic [6:0] SEXA_LAST_BIN = 7'h3B;
    localparam logic [6:0] SEXA_LAST_BCD = 7'h59;
    localparam logic [3:0] DIGIT_NINE = 4'h9;
    localparam logic [6:0] TEN_BIN = 7'h0A;
    localparam logic [5:0] HOUR_23_BIN = 6'h17;
    localparam logic [5:0] HOUR_23_BCD = 6'h23;
    localparam logic [5:0] HOUR_11_BIN = 6'h0B;
    localparam logic [5:0] HOUR_11_BCD = 6'h11;
    localparam logic [5:0] HOUR_12_BIN = 6'h0C;
    localparam logic [5:0] HOUR_12_BCD = 6'h12;
    localparam logic [5:0] HOUR_ONE = 6'h01;
    localparam logic [5:0] HOUR_ZERO = 6'h00;

    // Control reset values.
    localparam logic [EV_COUNT-1:0] FLAGS_RESET = 10'h000;

    typedef struct packed {
        logic [5:0] hour;
        logic meridiem;
        logic [6:0] min;
        logic [6:0] sec;
    } rtcrc_time_t;

endpackage

// [rtcrc_sexa_counter.sv]
`timescale 1ns/1ns
module rtcrc_sexa_counter (
    input wire logic clk,
    input wire logic load,
    input wire logic [6:0] load_val,
    input wire logic bcd,
    input wire logic inc,
    output logic [6:0] count_reg,
    output logic wrap,
    output logic tens_step
);

    function automatic logic at_last(input logic [6:0] v, input logic b);
        at_last = b ? (v == rtcrc_pkg::SEXA_LAST_BCD) : (v == rtcrc_pkg::SEXA_LAST_BIN);
    endfunction

    function automatic logic ones_nine(input logic [6:0] v, input logic b);
        ones_nine = b ? (v[3:0] == rtcrc_pkg::DIGIT_NINE) : ((v % rtcrc_pkg::TEN_BIN) == 7'h09);
    endfunction

    logic [6:0] count_next;

    always_comb begin
        if (at_last(count_reg, bcd)) begin
            count_next = 7'h00;
        end else if (bcd && count_reg[3:0] == rtcrc_pkg::DIGIT_NINE) begin
            count_next = {count_reg[6:4] + 3'h1, 4'h0};
        end else begin
            count_next = count_reg + 7'h01;
        end
    end

    // Counts 0 to 59 and wraps with a carry out.
    assign wrap = inc && at_last(count_reg, bcd);
    assign tens_step = inc && ones_nine(count_reg, bcd);

    // No reset: contents survive an initial reset.
    always_ff @(posedge clk) begin
        if (load) begin
            count_reg <= load_val;
        end else if (inc) begin
            count_reg <= count_next;
        end
    end

endmodule

// [rtcrc_top.sv]
`timescale 1ns/1ns
// What this block does
// - Time base advances on 256 Hz tick.
// - Tick ignored while block is stopped.
// - Starting run resets the shared divider.
// - Run bit zero and idle after reset.
// - Format bit picks 12 or 24 hours.
// - Meridiem bit writable, zero in 24-hour mode.
// - Count while run is one, halt at zero.
// - Status falls only when counting really stops.
// - Flag may rise right after restart.
// - Ten sources, each gated by its enable.
// - Day and half-day events as hour 11 or 23 ends.
// - Hour and ten-minute events on minutes.
// - Minute and ten-second events on seconds.
// - Prescaler gives 1, 4, 8, 32 Hz events.
// - Enabled event sets flag and raises request.
// - Writing one clears a flag.
// - Keeps running and interrupting in sleep.
// - Seconds and minutes count 0 to 59.
// - Hours count 0-23 or 1-12.
// - Reset leaves time counters unchanged.
module rtcrc_top (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic regulated_256hz_tick,
    input wire logic count_run_ctl,
    input wire logic hour_format_sel,
    input wire logic decimal_digit_mode,
    input wire logic time_load,
    input wire rtcrc_pkg::rtcrc_time_t time_load_val,
    input wire logic [rtcrc_pkg::EV_COUNT-1:0] irq_enable_reg,
    input wire logic [rtcrc_pkg::EV_COUNT-1:0] irq_flag_clear,
    output rtcrc_pkg::rtcrc_time_t time_reg,
    output logic count_active_status,
    output logic divider_restart_reg,
    output logic [rtcrc_pkg::EV_COUNT-1:0] irq_flag_reg,
    output logic irq_req_reg
);

    logic tick_meta_reg;
    logic tick_sync_reg;
    logic tick_prev_reg;
    logic tick_edge;
    logic run_prev_reg;
    logic run_start;
    logic active_reg;
    logic [rtcrc_pkg::PRESC_W-1:0] presc_reg;
    logic tick_en;
    logic ev_1hz;
    logic load_ok;
    logic [6:0] sec_val;
    logic [6:0] min_val;
    logic sec_wrap;
    logic sec_tens;
    logic min_wrap;
    logic min_tens;
    logic [5:0] hour_reg;
    logic pm_reg;
    logic [5:0] hour_next;
    logic pm_next;
    logic day_ev;
    logic half_ev;
    logic [rtcrc_pkg::EV_COUNT-1:0] events;
    logic [rtcrc_pkg::EV_COUNT-1:0] fire;

    function automatic logic [5:0] hour_inc(input logic [5:0] h, input logic bcd);
        if (bcd && h[3:0] == rtcrc_pkg::DIGIT_NINE) begin
            hour_inc = {h[5:4] + 2'h1, 4'h0};
        end else begin
            hour_inc = h + 6'h01;
        end
    endfunction

    function automatic logic is_hour(input logic [5:0] h, input logic bcd,
                                     input logic [5:0] bin_v, input logic [5:0] bcd_v);
        is_hour = bcd ? (h == bcd_v) : (h == bin_v);
    endfunction

    // The tick comes from the clock generator's domain.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tick_meta_reg <= 1'b0;
            tick_sync_reg <= 1'b0;
            tick_prev_reg <= 1'b0;
        end else begin
            tick_meta_reg <= regulated_256hz_tick;
            tick_sync_reg <= tick_meta_reg;
            tick_prev_reg <= tick_sync_reg;
        end
    end

    assign tick_edge = tick_sync_reg && !tick_prev_reg;

    // A rising run request restarts the shared divider.
    assign run_start = count_run_ctl && !run_prev_reg;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            run_prev_reg <= 1'b0;
            divider_restart_reg <= 1'b0;
        end else begin
            run_prev_reg <= count_run_ctl;
            divider_restart_reg <= run_start;
        end
    end

    // Run state changes only on a tick, so status tracks real counting.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            active_reg <= 1'b0;
        end else if (tick_edge) begin
            active_reg <= count_run_ctl;
        end
    end

    assign count_active_status = active_reg;
    assign tick_en = tick_edge && active_reg;

    // Prescaler restarts with the divider and holds while stopped.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            presc_reg <= rtcrc_pkg::PRESC_RESET;
        end else if (run_start) begin
            presc_reg <= rtcrc_pkg::PRESC_RESET;
        end else if (tick_en) begin
            presc_reg <= presc_reg + 8'h01;
        end
    end

    assign ev_1hz = tick_en && ((presc_reg & rtcrc_pkg::PRESC_1HZ_MASK) == rtcrc_pkg::PRESC_1HZ_MASK);

    // Counters accept a load only while stopped.
    assign load_ok = time_load && !active_reg;

    rtcrc_sexa_counter u_sec (
        .clk(clk),
        .load(load_ok),
        .load_val(time_load_val.sec),
        .bcd(decimal_digit_mode),
        .inc(ev_1hz),
        .count_reg(sec_val),
        .wrap(sec_wrap),
        .tens_step(sec_tens)
    );

    rtcrc_sexa_counter u_min (
        .clk(clk),
        .load(load_ok),
        .load_val(time_load_val.min),
        .bcd(decimal_digit_mode),
        .inc(sec_wrap),
        .count_reg(min_val),
        .wrap(min_wrap),
        .tens_step(min_tens)
    );

    // Hour range and meridiem follow the selected format.
    always_comb begin
        hour_next = hour_inc(hour_reg, decimal_digit_mode);
        pm_next = pm_reg;
        day_ev = 1'b0;
        half_ev = 1'b0;
        if (hour_format_sel) begin
            if (is_hour(hour_reg, decimal_digit_mode, rtcrc_pkg::HOUR_12_BIN, rtcrc_pkg::HOUR_12_BCD)) begin
                hour_next = rtcrc_pkg::HOUR_ONE;
            end else if (is_hour(hour_reg, decimal_digit_mode, rtcrc_pkg::HOUR_11_BIN,
                                 rtcrc_pkg::HOUR_11_BCD)) begin
                hour_next = decimal_digit_mode ? rtcrc_pkg::HOUR_12_BCD : rtcrc_pkg::HOUR_12_BIN;
                pm_next = !pm_reg;
                half_ev = 1'b1;
                day_ev = pm_reg;
            end
        end else begin
            pm_next = 1'b0;
            if (is_hour(hour_reg, decimal_digit_mode, rtcrc_pkg::HOUR_23_BIN, rtcrc_pkg::HOUR_23_BCD)) begin
                hour_next = rtcrc_pkg::HOUR_ZERO;
                half_ev = 1'b1;
                day_ev = 1'b1;
            end else if (is_hour(hour_reg, decimal_digit_mode, rtcrc_pkg::HOUR_11_BIN,
                                 rtcrc_pkg::HOUR_11_BCD)) begin
                half_ev = 1'b1;
            end
        end
    end

    // Hours and meridiem are not reset either.
    always_ff @(posedge clk) begin
        if (load_ok) begin
            hour_reg <= time_load_val.hour;
            pm_reg <= time_load_val.meridiem && hour_format_sel;
        end else if (min_wrap) begin
            hour_reg <= hour_next;
            pm_reg <= pm_next;
        end else if (!hour_format_sel) begin
            pm_reg <= 1'b0;
        end
    end

    always_comb begin
        time_reg.sec = sec_val;
        time_reg.min = min_val;
        time_reg.hour = hour_reg;
        time_reg.meridiem = pm_reg && hour_format_sel;
    end

    // Event sources.
    always_comb begin
        events = '0;
        events[rtcrc_pkg::EV_32HZ] = tick_en && ((presc_reg & rtcrc_pkg::PRESC_32HZ_MASK)
                                                 == rtcrc_pkg::PRESC_32HZ_MASK);
        events[rtcrc_pkg::EV_8HZ] = tick_en && ((presc_reg & rtcrc_pkg::PRESC_8HZ_MASK)
                                                == rtcrc_pkg::PRESC_8HZ_MASK);
        events[rtcrc_pkg::EV_4HZ] = tick_en && ((presc_reg & rtcrc_pkg::PRESC_4HZ_MASK)
                                                == rtcrc_pkg::PRESC_4HZ_MASK);
        events[rtcrc_pkg::EV_1HZ] = ev_1hz;
        events[rtcrc_pkg::EV_TENSEC] = sec_tens;
        events[rtcrc_pkg::EV_MINUTE] = sec_wrap;
        events[rtcrc_pkg::EV_TENMIN] = sec_wrap && min_tens;
        events[rtcrc_pkg::EV_HOUR] = min_wrap;
        events[rtcrc_pkg::EV_HALFDAY] = min_wrap && half_ev;
        events[rtcrc_pkg::EV_DAY] = min_wrap && day_ev;
    end

    assign fire = events & irq_enable_reg;

    // Flags: set wins over a simultaneous write-one clear.
    genvar gi;
    generate
        for (gi = 0; gi < rtcrc_pkg::EV_COUNT; gi++) begin : g_flag
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    irq_flag_reg[gi] <= rtcrc_pkg::FLAGS_RESET[gi];
                end else if (fire[gi]) begin
                    irq_flag_reg[gi] <= 1'b1;
                end else if (irq_flag_clear[gi]) begin
                    irq_flag_reg[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // No sleep gating exists here, so requests keep flowing in sleep.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_req_reg <= 1'b0;
        end else begin
            irq_req_reg <= |((irq_flag_reg | fire) & irq_enable_reg);
        end
    end

endmodule

// [rtcrc_tick_model.sv]
`timescale 1ns/1ns
module rtcrc_tick_model #(
    parameter int HALF = 4
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic restart,
    output logic tick
);
    int cnt;
    // Free-running square tick that restarts its period on request.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt <= 0;
            tick <= 1'b0;
        end else if (restart) begin
            cnt <= 0;
            tick <= 1'b0;
        end else if (cnt == HALF - 1) begin
            cnt <= 0;
            tick <= ~tick;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule

// [rtcrc_top_monitor.sv]
`timescale 1ns/1ns
module rtcrc_top_monitor (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic regulated_256hz_tick,
    input wire logic count_run_ctl,
    input wire logic hour_format_sel,
    input wire logic decimal_digit_mode,
    input wire logic time_load,
    input wire rtcrc_pkg::rtcrc_time_t time_load_val,
    input wire logic [9:0] irq_enable_reg,
    input wire logic [9:0] irq_flag_clear,
    input wire rtcrc_pkg::rtcrc_time_t time_reg,
    input wire logic count_active_status,
    input wire logic divider_restart_reg,
    input wire logic [9:0] irq_flag_reg,
    input wire logic irq_req_reg
);
    logic loaded_reg;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            loaded_reg <= 1'b0;
        end else if (time_load && !count_active_status) begin
            loaded_reg <= 1'b1;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence s_sec_wrap;
        loaded_reg && $past(count_active_status) && time_reg.sec == 7'h00
            && $past(time_reg.sec) == (decimal_digit_mode ? 7'h59 : 7'h3B);
    endsequence
    a_restart_after_run: assert property ($rose(count_run_ctl) |=> divider_restart_reg)
        else $error("divider restart missing");
    a_flag_needs_enable: assert property (!(|(irq_flag_reg & ~$past(irq_flag_reg) & ~$past(irq_enable_reg))))
        else $error("flag set while disabled");
    a_flag_sticky: assert property (!(|($past(irq_flag_reg) & ~irq_flag_reg & ~$past(irq_flag_clear))))
        else $error("flag dropped without clear");
    a_irq_raise: assert property (|(irq_flag_reg & irq_enable_reg) |=> irq_req_reg)
        else $error("request missing");
    a_irq_cause: assert property (irq_req_reg
        |-> |($past(irq_enable_reg) & (irq_flag_reg | $past(irq_flag_reg))))
        else $error("request without enabled flag");
    a_stopped_frozen: assert property (loaded_reg && !count_active_status && !time_load |=>
        $stable({time_reg.hour, time_reg.min, time_reg.sec})
            && time_reg.meridiem == ($past(time_reg.meridiem) && hour_format_sel))
        else $error("time moved while stopped");
    a_meridiem_24h: assert property (loaded_reg && !hour_format_sel |-> !time_reg.meridiem)
        else $error("meridiem set in 24-hour mode");
    a_status_fall: assert property ($fell(count_active_status) |-> !$past(count_run_ctl))
        else $error("status fell while run set");
    a_minute_event: assert property (s_sec_wrap ##0 $past(irq_enable_reg[5]) |-> ##[0:2] irq_flag_reg[5])
        else $error("minute flag missing");
endmodule
bind rtcrc_top rtcrc_top_monitor u_rtcrc_top_monitor (.clk(clk), .reset_n(reset_n),
    .regulated_256hz_tick(regulated_256hz_tick), .count_run_ctl(count_run_ctl), .hour_format_sel(hour_format_sel),
    .decimal_digit_mode(decimal_digit_mode), .time_load(time_load), .time_load_val(time_load_val),
    .irq_enable_reg(irq_enable_reg), .irq_flag_clear(irq_flag_clear), .time_reg(time_reg),
    .count_active_status(count_active_status), .divider_restart_reg(divider_restart_reg),
    .irq_flag_reg(irq_flag_reg), .irq_req_reg(irq_req_reg));

// [rtc_run_control_and_periodic_irq_tb_top.sv]
`timescale 1ns/1ns
module rtc_run_control_and_periodic_irq_tb_top;
    typedef struct {int kind; logic [20:0] exp;} rtcrc_note_t;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic tick, status, restart, irq, run = 1'b0, fmt = 1'b0, bcd = 1'b0, load = 1'b0;
    logic [9:0] en = 10'h000, clr = 10'h000, flags, mask;
    logic [9:0] exf [4];
    rtcrc_pkg::rtcrc_time_t load_val = '0, time_q;
    rtcrc_pkg::rtcrc_time_t ld [4], ex [4];
    logic [31:0] seed = 32'h39469B34;
    int n_fail = 0, checks = 0, cyc = 0, i;
    rtcrc_note_t notes [$];
    rtcrc_note_t cur;
    event ev;
    rtcrc_top u_rtcrc_top (.clk(clk), .reset_n(reset_n), .regulated_256hz_tick(tick), .count_run_ctl(run),
        .hour_format_sel(fmt), .decimal_digit_mode(bcd), .time_load(load), .time_load_val(load_val),
        .irq_enable_reg(en), .irq_flag_clear(clr), .time_reg(time_q), .count_active_status(status),
        .divider_restart_reg(restart), .irq_flag_reg(flags), .irq_req_reg(irq));
    rtcrc_tick_model u_rtcrc_tick_model (.clk(clk), .reset_n(reset_n), .restart(restart), .tick(tick));
    always #10 clk = ~clk;
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction
    task automatic test_done;
        $display("checks %0d failures %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic note(input int kind, input logic [20:0] exp);
        notes.push_back('{kind, exp});
        ->ev;
    endtask
    task automatic cmp_time(input logic [20:0] e, input logic [20:0] a);
        checks++;
        if (a !== e) begin
            n_fail++;
            $display("[FAIL] %0t time exp %h got %h", $time, e, a);
        end
    endtask
    task automatic cmp_bits(input logic [9:0] e, input logic [9:0] a);
        checks++;
        if (a !== e) begin
            n_fail++;
            $display("[FAIL] %0t bits exp %h got %h", $time, e, a);
        end
    endtask
    initial forever begin
        @(ev);
        while (notes.size() > 0) begin
            cur = notes.pop_front();
            case (cur.kind)
                0: cmp_time(cur.exp, time_q);
                1: cmp_bits(cur.exp[9:0], flags);
                default: cmp_bits(cur.exp[9:0], {8'h00, status, irq});
            endcase
        end
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 15000) begin
            n_fail++;
            test_done;
        end
    end
    initial begin
        ld = '{'{6'h17, 1'b0, 7'h3B, 7'h3B}, '{6'h23, 1'b0, 7'h59, 7'h59},
               '{6'h0B, 1'b1, 7'h3B, 7'h3B}, '{6'h11, 1'b0, 7'h59, 7'h59}};
        ex = '{'{6'h00, 1'b0, 7'h00, 7'h00}, '{6'h00, 1'b0, 7'h00, 7'h00},
               '{6'h0C, 1'b0, 7'h00, 7'h00}, '{6'h12, 1'b1, 7'h00, 7'h00}};
        exf = '{10'h3FF, 10'h3FF, 10'h3FF, 10'h1FF};
        repeat (5) @(negedge clk);
        reset_n = 1'b1;
        note(2, 21'h0);
        note(1, 21'h0);
        for (int c = 0; c < 4; c++) begin
            seed = xs(seed);
            mask = (c == 0) ? seed[9:0] : 10'h3FF;
            clr = 10'h3FF;
            fmt = (c > 1);
            bcd = (c % 2 == 1);
            load = 1'b1;
            load_val = ld[c];
            @(negedge clk);
            clr = 10'h000;
            load = 1'b0;
            en = mask;
            note(0, ld[c]);
            run = 1'b1;
            for (i = 0; i < 40 && status !== 1'b1; i++) @(negedge clk);
            note(2, 21'h2);
            load = 1'b1;
            load_val = '0;
            @(negedge clk);
            load = 1'b0;
            note(0, ld[c]);
            @(negedge clk);
            note(0, ld[c]);
            for (i = 0; i < 3000 && time_q.sec === ld[c].sec; i++) @(negedge clk);
            repeat (3) @(negedge clk);
            note(0, ex[c]);
            note(1, {11'h0, exf[c] & mask});
            note(2, {19'h0, 1'b1, |(exf[c] & mask)});
            run = 1'b0;
            for (i = 0; i < 40 && status !== 1'b0; i++) @(negedge clk);
            repeat (20) @(negedge clk);
            note(2, {19'h0, 1'b0, |(exf[c] & mask)});
            note(0, ex[c]);
            clr = 10'h3FF;
            @(negedge clk);
            clr = 10'h000;
            repeat (3) @(negedge clk);
            note(1, 21'h0);
            note(2, 21'h0);
            $display("test case %0d done", c);
        end
        reset_n = 1'b0;
        repeat (2) @(negedge clk);
        reset_n = 1'b1;
        note(0, ex[3]);
        note(2, 21'h0);
        $display("test case reset done");
        test_done;
    end
endmodule
